// ==== design/pfs_supervisor.sv ====
// Fault supervision of a four-channel low-side gate predriver
`timescale 1ns/1ps

// Summary of operation
// - Open-load checked only while the channel gate is off.
// - Gate turning off starts a 60 ms per-channel deglitch mask.
// - Mask covers only the first 60 ms; afterwards drain checked continuously.
// - Drain below reference after deglitch gives open-load fault and raises flag.
// - One serial fault bit per channel, bits 0 to 3.
// - Drain compared to selected reference; internal 1.25 V by default.
// - Over-voltage forces all four gates off.
// - Gates follow commands again once over-voltage clears.
// - Over-voltage asserts the fault flag.
// - Over-voltage never sets a serial fault bit.
// - Under-voltage forces all gates off; resumes automatically when cleared.
// - Under-voltage asserts the fault flag.
// - Under-voltage never sets a serial fault bit.
// - Battery fault suppresses load-fault reporting on flag and serial bits.
// - Load-fault reporting returns once battery fault is gone.
// - Fault gone before chip select falls is not captured.
// - Chip select falling releases flag unless a fault is still present.
// - Serial bits sampled at chip select fall, held while it stays low.
module pfs_supervisor #(
  parameter int NUM_CH = pfs_pkg::NUM_CH,
  parameter int TMR_W = pfs_pkg::TMR_W,
  parameter logic [pfs_pkg::TMR_W-1:0] OFF_DEGLITCH_CYC =
    pfs_pkg::TMR_W'(pfs_pkg::OFF_DEGLITCH_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,

  // Commanded gate state from the serial and parallel input logic
  input wire logic [NUM_CH-1:0] gate_cmd,

  // Chip select pin, active low
  input wire logic chip_select_b,

  // Drain comparators: drain below internal or external reference
  input wire logic [NUM_CH-1:0] drain_below_int_ref,
  input wire logic [NUM_CH-1:0] drain_below_ext_ref,
  input wire logic reference_source_select,

  // On-state shorted-load detection per channel
  input wire logic [NUM_CH-1:0] short_load_detect,

  // Battery level indications
  input wire logic bat_over_volt,
  input wire logic bat_under_volt,

  // Gate drive outputs
  output logic [NUM_CH-1:0] gate_drive_outputs,

  // Open-drain fault flag pin
  input wire logic fault_flag_in,
  output logic fault_flag_out,
  output logic fault_flag_oe_b,
  output logic fault_line_low,

  // Fault status
  output logic fault_flag_active,
  output logic [NUM_CH-1:0] serial_fault_word,
  output logic battery_fault
);

  // ==========================================================
  // Input synchronisers
  localparam int SYNC_W = 3 * NUM_CH + 5;

  logic [SYNC_W-1:0] async_bus;
  logic [SYNC_W-1:0] sync_bus;
  // Reset image of the synchroniser: chip select and flag line idle high
  localparam logic [SYNC_W-1:0] SYNC_RST =
    {{(SYNC_W-2){1'b0}}, pfs_pkg::CS_IDLE, pfs_pkg::PIN_IDLE};

  logic [NUM_CH-1:0] below_int_s;
  logic [NUM_CH-1:0] below_ext_s;
  logic [NUM_CH-1:0] short_s;
  logic ref_sel_s;
  logic ov_s;
  logic uv_s;
  logic cs_b_s;
  logic flag_line_s;

  assign async_bus = {drain_below_int_ref, drain_below_ext_ref, short_load_detect,
                      reference_source_select, bat_over_volt, bat_under_volt,
                      chip_select_b, fault_flag_in};

  // Every pin-level indication is retimed before use
  pfs_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  assign below_int_s = sync_bus[SYNC_W-1 -: NUM_CH];
  assign below_ext_s = sync_bus[SYNC_W-1-NUM_CH -: NUM_CH];
  assign short_s = sync_bus[SYNC_W-1-2*NUM_CH -: NUM_CH];
  assign ref_sel_s = sync_bus[4];
  assign ov_s = sync_bus[3];
  assign uv_s = sync_bus[2];
  assign cs_b_s = sync_bus[1];
  assign flag_line_s = sync_bus[0];

  // ==========================================================
  // Helpers
  function automatic logic tmr_done(input logic [TMR_W-1:0] cnt);
    tmr_done = (cnt == '0);
  endfunction : tmr_done

  function automatic logic [NUM_CH-1:0] pick_ref(
    input logic sel,
    input logic [NUM_CH-1:0] int_cmp,
    input logic [NUM_CH-1:0] ext_cmp
  );
    pick_ref = sel ? ext_cmp : int_cmp;
  endfunction : pick_ref

  // ==========================================================
  // Battery supervision and gate forcing
  logic bat_fault;
  logic [NUM_CH-1:0] gate_r;
  logic [NUM_CH-1:0] gate_nxt;
  logic [NUM_CH-1:0] gate_fall;

  assign bat_fault = ov_s | uv_s;

  always_comb begin
    // Over- or under-voltage holds every gate off; release is automatic
    gate_nxt = gate_cmd & ~{NUM_CH{bat_fault}};
    gate_fall = gate_r & ~gate_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gate_r <= pfs_pkg::GATE_RST;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // ==========================================================
  // Off-state deglitch timers
  logic [TMR_W-1:0] tmr_r [NUM_CH];
  logic [TMR_W-1:0] tmr_nxt [NUM_CH];

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      tmr_nxt[i] = tmr_r[i];
      if (gate_fall[i]) begin
        // Each turn-off restarts the mask window
        tmr_nxt[i] = OFF_DEGLITCH_CYC;
      end else if (!gate_r[i] && !tmr_done(tmr_r[i])) begin
        tmr_nxt[i] = tmr_r[i] - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        tmr_r[i] <= OFF_DEGLITCH_CYC;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        tmr_r[i] <= tmr_nxt[i];
      end
    end
  end

  // ==========================================================
  // Load fault qualification
  logic [NUM_CH-1:0] drain_below;
  logic [NUM_CH-1:0] open_load;
  logic [NUM_CH-1:0] load_fault;
  logic any_fault;

  always_comb begin
    // Default internal reference, external one when selected
    drain_below = pick_ref(ref_sel_s, below_int_s, below_ext_s);
    for (int i = 0; i < NUM_CH; i++) begin
      // Only with gate off and past the mask window
      open_load[i] = !gate_r[i] && tmr_done(tmr_r[i]) && drain_below[i];
    end
    // Load faults hidden while the battery is out of range
    load_fault = (open_load | short_s) & ~{NUM_CH{bat_fault}};
    // Battery faults count toward the flag only
    any_fault = bat_fault | (|load_fault);
  end

  // ==========================================================
  // Chip select edges, fault flag and serial fault word
  logic cs_b_d_r;
  logic cs_b_d_nxt;
  logic cs_fall;
  logic cs_rise;
  logic flag_r;
  logic flag_nxt;
  logic pin_r;
  logic pin_nxt;
  logic line_low_r;
  logic line_low_nxt;
  logic bat_r;
  logic bat_nxt;
  logic [NUM_CH-1:0] word_r;
  logic [NUM_CH-1:0] word_nxt;

  always_comb begin
    cs_b_d_nxt = cs_b_s;
    cs_fall = cs_b_d_r & ~cs_b_s;
    cs_rise = ~cs_b_d_r & cs_b_s;

    // A present fault sets the flag and wins over the release
    flag_nxt = any_fault | (flag_r & ~cs_fall);
    pin_nxt = ~flag_nxt;
    line_low_nxt = ~flag_line_s;
    bat_nxt = bat_fault;

    // Only load faults reach the word, one bit per channel
    if (cs_fall) begin
      // Sampled from live state: vanished faults are not captured
      word_nxt = load_fault;
    end else if (!cs_b_s) begin
      word_nxt = word_r;
    end else if (cs_rise) begin
      word_nxt = pfs_pkg::WORD_RST;
    end else begin
      word_nxt = load_fault;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cs_b_d_r <= pfs_pkg::CS_IDLE;
      flag_r <= pfs_pkg::FLAG_RST;
      pin_r <= pfs_pkg::PIN_IDLE;
      line_low_r <= 1'b0;
      bat_r <= 1'b0;
      word_r <= pfs_pkg::WORD_RST;
    end else begin
      cs_b_d_r <= cs_b_d_nxt;
      flag_r <= flag_nxt;
      pin_r <= pin_nxt;
      line_low_r <= line_low_nxt;
      bat_r <= bat_nxt;
      word_r <= word_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign gate_drive_outputs = gate_r;
  assign fault_flag_out = pin_r;
  assign fault_flag_oe_b = pin_r;
  assign fault_line_low = line_low_r;
  assign fault_flag_active = flag_r;
  assign serial_fault_word = word_r;
  assign battery_fault = bat_r;

endmodule : pfs_supervisor

// ==== design/pfs_pkg.sv ====
// Constants shared by the predriver fault supervisor
package pfs_pkg;

  // ==========================================================
  // Channel layout
  localparam int NUM_CH = 4;

  // ==========================================================
  // Clock and deglitch timing
  localparam int CLK_FREQ_KHZ = 250_000;
  localparam int OFF_DEGLITCH_MS = 60;
  localparam int OFF_DEGLITCH_CYC = OFF_DEGLITCH_MS * CLK_FREQ_KHZ;
  localparam int TMR_W = 24;

  // ==========================================================
  // Values after reset
  localparam logic [NUM_CH-1:0] GATE_RST = 4'h0;
  localparam logic [NUM_CH-1:0] WORD_RST = 4'h0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic CS_IDLE = 1'b1;
  localparam int SYNC_STAGES = 2;

endpackage : pfs_pkg

// ==== design/pfs_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps

module pfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ==========================================================
  // Flops
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : pfs_sync

// ==== tb/pfs_sup_asserts.sv ====
// Checker for the predriver fault supervisor
`timescale 1ns/1ps
module pfs_sup_chk #(
  parameter int DEG_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic chip_select_b,
  input wire logic [3:0] gate_cmd,
  input wire logic [3:0] gate_drive_outputs,
  input wire logic fault_flag_out,
  input wire logic fault_flag_oe_b,
  input wire logic fault_flag_active,
  input wire logic [3:0] serial_fault_word,
  input wire logic battery_fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Cycles channel 0 gate has been off
  int off_cnt_r;
  always_ff @(posedge core_clk) begin
    off_cnt_r <= (!rst_b || gate_drive_outputs[0]) ? 0 : off_cnt_r + 1;
  end
  // ==========================================================
  // Properties
  gate_forced_a: assert property (battery_fault |-> gate_drive_outputs == 4'h0)
    else $error("gates on during battery fault");
  gate_follow_a: assert property (gate_drive_outputs == ($past(gate_cmd) & {4{!battery_fault}}))
    else $error("gates do not follow command");
  flag_pin_a: assert property (fault_flag_oe_b == !fault_flag_active && fault_flag_out == fault_flag_oe_b)
    else $error("flag pin disagrees with flag");
  bat_flag_a: assert property (battery_fault |-> fault_flag_active)
    else $error("battery fault without flag");
  word_clean_a: assert property (battery_fault && chip_select_b && $past(chip_select_b, 4)
    |-> serial_fault_word == 4'h0)
    else $error("fault word set during battery fault");
  flag_release_a: assert property ($fell(fault_flag_active) |-> !$past(chip_select_b, 2))
    else $error("flag released without select fall");
  word_hold_a: assert property (!chip_select_b [*6] |-> $stable(serial_fault_word))
    else $error("fault word moved while selected");
  deglitch_a: assert property ($rose(serial_fault_word[0]) |-> off_cnt_r >= DEG_CYC)
    else $error("open load reported inside deglitch");
  cover property (battery_fault);
  cover property ($fell(fault_flag_active));
  cover property ($rose(serial_fault_word[0]));
endmodule : pfs_sup_chk

bind pfs_supervisor pfs_sup_chk #(.DEG_CYC(OFF_DEGLITCH_CYC)) u_chk (.core_clk(core_clk),
  .rst_b(rst_b), .chip_select_b(chip_select_b), .gate_cmd(gate_cmd),
  .gate_drive_outputs(gate_drive_outputs), .fault_flag_out(fault_flag_out),
  .fault_flag_oe_b(fault_flag_oe_b), .fault_flag_active(fault_flag_active),
  .serial_fault_word(serial_fault_word), .battery_fault(battery_fault));

// ==== tb/pfs_host.sv ====
// Host model: pulled-up flag wire and serial fault reads
`timescale 1ns/1ps
module pfs_host (
  // Clock
  input wire logic core_clk,
  // Flag pin and fault word
  input wire logic fault_flag_out,
  input wire logic fault_flag_oe_b,
  input wire logic [3:0] serial_fault_word,
  output logic fault_flag_in,
  output logic chip_select_b
);
  // Pull-up holds the line high while nobody drives it
  assign fault_flag_in = fault_flag_oe_b ? 1'b1 : fault_flag_out;
  initial chip_select_b = 1'b1;
  // Select, wait for capture, take the word, deselect
  task automatic read_word(output logic [3:0] w);
    @(posedge core_clk) chip_select_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    w = serial_fault_word;
    chip_select_b <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : read_word
endmodule : pfs_host

// ==== tb/tb_top.sv ====
// Self-checking bench for the predriver fault supervisor
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ref_sel = 1'b0;
  logic ov = 1'b0;
  logic uv = 1'b0;
  logic [3:0] gate_cmd = 4'h0;
  logic [3:0] below_int = 4'h0;
  logic [3:0] below_ext = 4'h0;
  logic [3:0] short = 4'h0;
  logic [3:0] gates, word, w;
  logic flag_out, flag_oe_b, line_low, flag_act, bat_fault, flag_in, cs_b;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========================================================
  // Design and host
  pfs_supervisor #(.OFF_DEGLITCH_CYC(24'h00_0014)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .gate_cmd(gate_cmd), .chip_select_b(cs_b), .drain_below_int_ref(below_int),
    .drain_below_ext_ref(below_ext), .reference_source_select(ref_sel),
    .short_load_detect(short), .bat_over_volt(ov), .bat_under_volt(uv),
    .gate_drive_outputs(gates), .fault_flag_in(flag_in), .fault_flag_out(flag_out),
    .fault_flag_oe_b(flag_oe_b), .fault_line_low(line_low), .fault_flag_active(flag_act),
    .serial_fault_word(word), .battery_fault(bat_fault));
  pfs_host u_host (.core_clk(core_clk), .fault_flag_out(flag_out),
    .fault_flag_oe_b(flag_oe_b), .serial_fault_word(word), .fault_flag_in(flag_in),
    .chip_select_b(cs_b));
  // ==========================================================
  // Helpers
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Open load on one channel against the chosen reference
  task automatic s_open(int ch, logic sel);
    logic [3:0] m;
    m = 4'h1 << ch;
    ref_sel <= sel;
    gate_cmd <= m;
    if (sel) below_ext <= m;
    else below_int <= m;
    tick(30);
    chk(word, 4'h0);
    gate_cmd <= 4'h0;
    tick(15);
    chk(word, 4'h0);
    tick(15);
    chk(word, m);
    chk({3'h0, line_low}, 4'h1);
    u_host.read_word(w);
    chk(w, m);
    below_int <= 4'h0;
    below_ext <= 4'h0;
    tick(4);
    chk({3'h0, flag_act}, 4'h1);
    u_host.read_word(w);
    chk(w, 4'h0);
    chk({3'h0, flag_act}, 4'h0);
  endtask : s_open
  // Battery fault over a pending open load on channel 3
  task automatic s_bat(logic o);
    ref_sel <= 1'b0;
    gate_cmd <= 4'h7;
    below_int <= 4'h8;
    tick(30);
    chk(word, 4'h8);
    short <= 4'h1;
    if (o) ov <= 1'b1;
    else uv <= 1'b1;
    tick(5);
    chk(gates, 4'h0);
    chk({2'h0, bat_fault, flag_act}, 4'h3);
    chk(word, 4'h0);
    u_host.read_word(w);
    chk(w, 4'h0);
    ov <= 1'b0;
    uv <= 1'b0;
    short <= 4'h0;
    tick(5);
    chk(gates, 4'h7);
    chk(word, 4'h8);
    below_int <= 4'h0;
    u_host.read_word(w);
    chk(w, 4'h0);
  endtask : s_bat
  // ==========================================================
  // Clock, timeout and main sequence
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    tick(20);
    rst_b <= 1'b1;
    tick(5);
    s_open(0, 1'b0);
    s_open(2, 1'b1);
    s_bat(1'b1);
    s_bat(1'b0);
    report_and_stop();
  end
endmodule : tb_top
